// ---- bench/pbm_sta_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Station management host: runs the management clock and shares the data line
module pbm_sta_model (
	// Device side of the data pin
	input  wire logic i_dev_mdio,
	input  wire logic i_dev_oe_n,
	// Pins toward the device
	output logic      o_mdc,
	output logic      o_mdio_line
);
	logic host_oe;
	logic host_do;
	// Pull-up holds the line high when nobody drives it
	assign o_mdio_line = !i_dev_oe_n ? i_dev_mdio : (host_oe ? host_do : 1'b1);
	initial begin
		o_mdc = 1'b0;
		host_oe = 1'b0;
		host_do = 1'b1;
	end
	// One frame with preamble; the clock stands low between frames
	task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rdat);
		logic [63:0] bits;
		bits = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, phy, ra, 2'b10, wd};
		rdat = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			host_oe = !rd || i >= 18;
			host_do = bits[i];
			#62.5 o_mdc = 1'b1;
			if (i < 16)
				rdat[i] = o_mdio_line;
			#62.5 o_mdc = 1'b0;
		end
		host_oe = 1'b0;
	endtask
endmodule
`default_nettype wire

// ---- bench/tb_phy_basic_mgmt_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs_map.svh"
module tb_phy_basic_mgmt_regs;
	logic               clk_sys;
	logic               rst_n;
	logic               mdc;
	logic               mdio_line;
	logic               mdio_o;
	logic               mdio_oe_n;
	logic [4:0]         phy_addr;
	logic [4:0]         tgt;
	pbm_pkg::pbm_line_t line;
	pbm_pkg::pbm_mode_t mode;
	logic               an_started;
	logic               an_restart;
	logic               core_reset;
	logic               tx_en;
	logic [7:0]         txd;
	logic               rx_dv;
	logic [7:0]         rxd;
	logic               col;
	logic               mac_oe_n;
	logic               line_tx_en;
	logic [7:0]         line_txd;
	logic [15:0]        rd_v;
	logic [15:0]        w;
	logic [15:0]        ctrl_m;
	logic               seen;
	int                 miscompares;
	int                 n_tests;
	logic [15:0]        modes [5] = '{16'h0000, 16'h4000, 16'h0080, 16'h0400, 16'h0800};

	// Device under test and the management host
	pbm_basic_regs DUT (.i_clk_sys(clk_sys), .i_rst_n(rst_n), .i_mdc(mdc), .i_mdio(mdio_line),
		.i_phy_addr(phy_addr), .o_mdio(mdio_o), .o_mdio_oe_n(mdio_oe_n), .i_line(line),
		.i_an_started(an_started), .o_an_restart(an_restart), .o_core_reset(core_reset),
		.o_mode(mode), .i_tx_en(tx_en), .i_txd(txd), .o_rx_dv(rx_dv), .o_rxd(rxd), .o_col(col),
		.o_mac_oe_n(mac_oe_n), .o_line_tx_en(line_tx_en), .o_line_txd(line_txd));
	pbm_sta_model STA (.i_dev_mdio(mdio_o), .i_dev_oe_n(mdio_oe_n), .o_mdc(mdc), .o_mdio_line(mdio_line));

	// System clock
	initial clk_sys = 1'b0;
	always #5 clk_sys = ~clk_sys;

	task automatic report_and_stop();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
		STA.frame(1'b0, tgt, ra, wd, rd_v);
		cyc(10);
	endtask
	task automatic rd(input logic [4:0] ra);
		STA.frame(1'b1, tgt, ra, 16'h0000, rd_v);
		cyc(10);
	endtask
	// Reference model of the control register and the resolved mode
	function automatic logic [15:0] ctrl_exp(input logic [15:0] v);
		logic [15:0] c;
		c = v & 16'h7fc0;
		if (!c[12])
			c[9] = 1'b0;
		return c;
	endfunction
	function automatic logic [15:0] mode_exp(input logic [15:0] c);
		logic [1:0] spd;
		logic       fd;
		spd = c[12] ? 2'd2 : {c[6], c[13]};
		fd = (c[12] || c[14] || spd == 2'd2) ? 1'b1 : c[8];
		return {8'h00, c[14], c[11], c[10], c[7], c[12], fd, spd};
	endfunction
	function automatic logic [15:0] stat_exp(input logic an, input logic rf, input logic ls, input logic jd);
		return (16'h7949 & 16'hffc9) | {10'h000, an, rf, 1'b0, ls, jd, 1'b0};
	endfunction

	// Watchdog sized well above the expected run of about 49 frames
	initial begin
		#1_000_000;
		miscompares++;
		report_and_stop();
	end

	initial begin
		rst_n = 1'b0;
		phy_addr = 5'h03;
		tgt = 5'h03;
		line = 4'b0000;
		an_started = 1'b0;
		tx_en = 1'b0;
		txd = 8'h00;
		void'($urandom(32'haac8));
		cyc(4);
		rst_n <= 1'b1;
		cyc(4);
		rd(5'h00);
		chk("ctrl reset", rd_v, 16'h1140);
		chk("mode reset", {8'h00, mode}, mode_exp(16'h1140));
		rd(5'h02);
		chk("id", rd_v, `PBM_ID_HIGH_VALUE);
		rd(5'h05);
		chk("unmapped", rd_v, 16'h0000);
		tgt = 5'h1c;
		rd(5'h00);
		chk("other address", rd_v, 16'hffff);
		tgt = 5'h03;
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			w = (i < 4) ? (16'h0100 | {2'b00, i[0], 6'h00, i[1], 6'h00}) : 16'($urandom) & 16'h7fff;
			wr(5'h00, w);
			rd(5'h00);
			ctrl_m = ctrl_exp(w);
			chk("ctrl", rd_v, ctrl_m);
			chk("mode", {8'h00, mode}, mode_exp(ctrl_m));
			chk("restart out", {15'h0000, an_restart}, {15'h0000, ctrl_m[9]});
		end
		$display("test control done");
		wr(5'h00, 16'h1340);
		chk("restart set", {15'h0000, an_restart}, 16'h0001);
		an_started <= 1'b1;
		cyc(1);
		an_started <= 1'b0;
		cyc(6);
		rd(5'h00);
		chk("restart cleared", rd_v, 16'h1140);
		$display("test restart done");
		line <= 4'b1001;
		cyc(6);
		rd(5'h01);
		wr(5'h01, 16'h0000);
		wr(5'h02, 16'h0000);
		rd(5'h01);
		chk("status", rd_v, stat_exp(1'b1, 1'b0, 1'b1, 1'b0));
		rd(5'h02);
		chk("id write", rd_v, `PBM_ID_HIGH_VALUE);
		line <= 4'b0111;
		cyc(6);
		line <= 4'b1001;
		cyc(6);
		rd(5'h01);
		chk("latched", rd_v, stat_exp(1'b1, 1'b1, 1'b0, 1'b1));
		line <= 4'b1000;
		cyc(6);
		rd(5'h01);
		chk("after read", rd_v, stat_exp(1'b0, 1'b0, 1'b1, 1'b0));
		$display("test status done");
		for (int i = 0; i < 5; i++) begin
			wr(5'h00, modes[i]);
			tx_en <= 1'b1;
			txd <= 8'($urandom);
			cyc(6);
			chk("mac oe", {15'h0000, mac_oe_n}, {15'h0000, modes[i][10] | modes[i][11]});
			chk("rx dv", {15'h0000, rx_dv}, {15'h0000, modes[i][14]});
			chk("col", {15'h0000, col}, {15'h0000, modes[i][7]});
			chk("line tx", {15'h0000, line_tx_en}, {15'h0000, modes[i][14:10] == 5'h00});
			if (modes[i][14])
				chk("rxd", {8'h00, rxd}, {8'h00, txd});
			if (modes[i] == 16'h0000)
				chk("line txd", {8'h00, line_txd}, {8'h00, txd});
			tx_en <= 1'b0;
			cyc(6);
			chk("col idle", {15'h0000, col}, 16'h0000);
			rd(5'h00);
			chk("mgmt alive", rd_v, modes[i]);
		end
		$display("test mac done");
		// Poll straight after the frame: the reset pulse is shorter than the gap in wr
		STA.frame(1'b0, tgt, 5'h00, 16'h8100, rd_v);
		seen = 1'b0;
		for (int k = 0; k < 20 && !seen; k++) begin
			@(negedge clk_sys);
			seen = (core_reset === 1'b1);
		end
		chk("core reset", {15'h0000, seen}, 16'h0001);
		cyc(20);
		rd(5'h00);
		chk("after soft reset", rd_v, 16'h1140);
		chk("mode soft reset", {8'h00, mode}, mode_exp(16'h1140));
		$display("test soft reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ---- hw/pbm_basic_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs_map.svh"
// Function
// RL1: Soft reset restores defaults, then self-clears
// RL2: Loopback returns transmit to receive, COL low; the code still copies transmit enable onto COL when collision test is also set
// RL3: Speed bits 00/01/10 select 10/100/1000
// RL4: Autoneg enable overrides forced speed and duplex
// RL5: Power down stops MAC interface, management stays
// RL6: Detach ignores MAC inputs, floats MAC outputs
// RL7: Restart self-clears; ignored when autoneg off
// RL8: Duplex only forced, 10/100, not loopback
// RL9: Collision test copies transmit enable onto COL
// RL10: Reserved control bits read zero, unwritable
// RL11: Status register ignores writes
// RL12: Fixed ability bits report supported modes
// RL13: Preamble optional bit reads one
// RL14: Autoneg done reads line negotiation state
// RL15: Remote fault latches high until read
// RL16: Link status latches low until read
// RL17: Jabber latches high until read
// RL18: Extended status bit reads one
// RL19: Autoneg and extra-register ability reads one
// RL20: Identifier register is read-only constant
// RL21: Self-clearing bits clear without host write
// RL22: Access over Clause 22 frames, 16-bit registers
// RL23: Latched flags hold until read, then follow
module pbm_basic_regs (
	// Clock and reset
	input  wire logic                  i_clk_sys,
	input  wire logic                  i_rst_n,
	// Management pins
	input  wire logic                  i_mdc,
	input  wire logic                  i_mdio,
	input  wire logic [4:0]            i_phy_addr,
	output logic                       o_mdio,
	output logic                       o_mdio_oe_n,
	// Line-side status and negotiation handshake
	input  wire pbm_pkg::pbm_line_t    i_line,
	input  wire logic                  i_an_started,
	output logic                       o_an_restart,
	output logic                       o_core_reset,
	output pbm_pkg::pbm_mode_t         o_mode,
	// MAC interface
	input  wire logic                  i_tx_en,
	input  wire logic [7:0]            i_txd,
	output logic                       o_rx_dv,
	output logic [7:0]                 o_rxd,
	output logic                       o_col,
	output logic                       o_mac_oe_n,
	output logic                       o_line_tx_en,
	output logic [7:0]                 o_line_txd
);
	pbm_pkg::pbm_acc_t  acc;
	pbm_pkg::pbm_line_t line_s1_q;
	pbm_pkg::pbm_line_t line_q;
	logic [1:0]         tx_en_sync_q;
	logic [7:0]         txd_s1_q;
	logic [7:0]         txd_s2_q;
	logic [15:0]        ctrl_q;
	logic [3:0]         rst_cnt_q;
	logic               rf_lat_q;
	logic               jab_lat_q;
	logic               link_lat_q;
	logic               rd_start;
	logic               stat_read;
	logic [15:0]        stat_word;
	logic [15:0]        rdata;
	logic               mac_live;
	// Serial management slave
	pbm_mdio_slave u_mdio (
		.i_clk_sys  (i_clk_sys),
		.i_rst_n    (i_rst_n),
		.i_mdc      (i_mdc),
		.i_mdio     (i_mdio),
		.i_phy_addr (i_phy_addr),
		.o_mdio     (o_mdio),
		.o_mdio_oe_n(o_mdio_oe_n),
		.o_acc      (acc),
		.o_rd_start (rd_start),
		.i_rdata    (rdata)
	); // RL22
	// Resolve speed from the two select bits
	function automatic pbm_pkg::pbm_speed_t spd_decode(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'b00:   spd_decode = pbm_pkg::PBM_SPD_10;
			2'b01:   spd_decode = pbm_pkg::PBM_SPD_100;
			2'b10:   spd_decode = pbm_pkg::PBM_SPD_1000;
			default: spd_decode = pbm_pkg::PBM_SPD_RSVD;
		endcase
	endfunction
	// Synchronise line status, transmit enable and transmit data
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			line_s1_q    <= '0;
			line_q       <= '0;
			tx_en_sync_q <= 2'h0;
			txd_s1_q     <= 8'h0;
			txd_s2_q     <= 8'h0;
		end else begin
			line_s1_q    <= i_line;
			line_q       <= line_s1_q;
			tx_en_sync_q <= {tx_en_sync_q[0], i_tx_en};
			txd_s1_q     <= i_txd;
			txd_s2_q     <= txd_s1_q;
		end
	end
	assign stat_read = rd_start && (acc.reg_addr == `PBM_ADDR_STAT);
	// Control register with self-clearing reset and restart
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_q    <= `PBM_CTRL_RESET;
			rst_cnt_q <= 4'h0;
		end else if (ctrl_q[`PBM_CTRL_SOFT_RST]) begin
			rst_cnt_q <= rst_cnt_q + 4'h1;
			if (rst_cnt_q == `PBM_SOFT_RST_CYC) begin
				ctrl_q    <= `PBM_CTRL_RESET; // RL1 RL21
				rst_cnt_q <= 4'h0;
			end
		end else begin
			if (acc.wr && acc.reg_addr == `PBM_ADDR_CTRL) begin
				ctrl_q <= acc.wdata & `PBM_CTRL_WMASK; // RL10
				if (!acc.wdata[`PBM_CTRL_AN_EN]) begin
					ctrl_q[`PBM_CTRL_AN_RESTART] <= 1'b0; // RL7
				end
			end else if (i_an_started) begin
				ctrl_q[`PBM_CTRL_AN_RESTART] <= 1'b0; // RL7 RL21
			end
		end
	end
	assign o_core_reset = ctrl_q[`PBM_CTRL_SOFT_RST]; // RL1
	assign o_an_restart = ctrl_q[`PBM_CTRL_AN_RESTART] & ctrl_q[`PBM_CTRL_AN_EN];
	// Latched status flags; an event in the read cycle wins
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rf_lat_q   <= 1'b0;
			jab_lat_q  <= 1'b0;
			link_lat_q <= 1'b0;
		end else begin
			rf_lat_q   <= line_q.remote_fault | (rf_lat_q & ~stat_read); // RL15 RL23
			jab_lat_q  <= line_q.jabber_seen | (jab_lat_q & ~stat_read); // RL17 RL23
			link_lat_q <= line_q.link_up & (link_lat_q | stat_read); // RL16 RL23
		end
	end
	// Status word: fixed abilities plus dynamic bits
	always_comb begin
		stat_word = `PBM_STAT_FIXED; // RL12 RL13 RL18 RL19
		stat_word[`PBM_STAT_AN_DONE] = line_q.autoneg_done; // RL14
		stat_word[`PBM_STAT_RFAULT]  = rf_lat_q;
		stat_word[`PBM_STAT_LINK]    = link_lat_q;
		stat_word[`PBM_STAT_JABBER]  = jab_lat_q;
	end
	// Read multiplexer; status and identifier have no write path
	always_comb begin
		unique case (acc.reg_addr)
			`PBM_ADDR_CTRL:    rdata = ctrl_q;
			`PBM_ADDR_STAT:    rdata = stat_word; // RL11
			`PBM_ADDR_ID_HIGH: rdata = `PBM_ID_HIGH_VALUE; // RL20
			default:           rdata = 16'h0;
		endcase
	end
	// Operating mode resolution
	always_comb begin
		o_mode.loopback       = ctrl_q[`PBM_CTRL_LOOPBACK];
		o_mode.power_down     = ctrl_q[`PBM_CTRL_PWR_DOWN];
		o_mode.mac_detach     = ctrl_q[`PBM_CTRL_DETACH];
		o_mode.col_test       = ctrl_q[`PBM_CTRL_COL_TEST];
		o_mode.autoneg_enable = ctrl_q[`PBM_CTRL_AN_EN];
		o_mode.speed          = ctrl_q[`PBM_CTRL_AN_EN] ? pbm_pkg::PBM_SPD_1000 :
			spd_decode(ctrl_q[`PBM_CTRL_SPD_HIGH], ctrl_q[`PBM_CTRL_SPD_LOW]); // RL3 RL4
		o_mode.full_duplex    = (ctrl_q[`PBM_CTRL_AN_EN] || ctrl_q[`PBM_CTRL_LOOPBACK] ||
			o_mode.speed == pbm_pkg::PBM_SPD_1000) ? 1'b1 : ctrl_q[`PBM_CTRL_DUPLEX]; // RL8 RL4
	end
	assign mac_live = ~ctrl_q[`PBM_CTRL_PWR_DOWN] & ~ctrl_q[`PBM_CTRL_DETACH] & ~ctrl_q[`PBM_CTRL_SOFT_RST];
	// MAC datapath: loopback, line transmit, collision test
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rx_dv      <= 1'b0;
			o_rxd        <= 8'h0;
			o_col        <= 1'b0;
			o_line_tx_en <= 1'b0;
			o_line_txd   <= 8'h0;
		end else begin
			o_rx_dv      <= mac_live & ctrl_q[`PBM_CTRL_LOOPBACK] & tx_en_sync_q[1]; // RL2 RL5 RL6
			o_rxd        <= (mac_live & ctrl_q[`PBM_CTRL_LOOPBACK]) ? txd_s2_q : 8'h0; // RL2
			o_line_tx_en <= mac_live & ~ctrl_q[`PBM_CTRL_LOOPBACK] & tx_en_sync_q[1]; // RL2 RL5
			o_line_txd   <= (mac_live & ~ctrl_q[`PBM_CTRL_LOOPBACK]) ? txd_s2_q : 8'h0;
			o_col        <= mac_live & ctrl_q[`PBM_CTRL_COL_TEST] & tx_en_sync_q[1]; // RL9
		end
	end
	assign o_mac_oe_n = ~mac_live; // RL6 RL5
	// Assertions
	// Soft reset: starts on a write, ends with the defaults back
	sequence s_soft_rst_begin;
		$rose(ctrl_q[`PBM_CTRL_SOFT_RST]);
	endsequence
	sequence s_soft_rst_done;
		ctrl_q == `PBM_CTRL_RESET;
	endsequence
	property p_soft_rst_clears;
		@(posedge i_clk_sys) disable iff (!i_rst_n) s_soft_rst_begin |-> ##[1:12] s_soft_rst_done;
	endproperty
	a_soft_rst_clears: assert property (p_soft_rst_clears) else $error("soft reset stuck"); // RL1
	property p_reserved_zero;
		@(posedge i_clk_sys) disable iff (!i_rst_n) ctrl_q[5:0] == 6'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set"); // RL10
	property p_loop_no_line;
		@(posedge i_clk_sys) disable iff (!i_rst_n) ctrl_q[14] |=> !o_line_tx_en;
	endproperty
	a_loop_no_line: assert property (p_loop_no_line) else $error("line driven in loopback"); // RL2
	property p_col_test;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(mac_live && ctrl_q[7] && tx_en_sync_q[1]) |=> o_col;
	endproperty
	a_col_test: assert property (p_col_test) else $error("collision test not copied"); // RL9
	property p_detach_float;
		@(posedge i_clk_sys) disable iff (!i_rst_n) ctrl_q[10] |-> o_mac_oe_n;
	endproperty
	a_detach_float: assert property (p_detach_float) else $error("outputs driven when detached"); // RL6
	property p_restart_off;
		@(posedge i_clk_sys) disable iff (!i_rst_n) !ctrl_q[12] |-> !ctrl_q[9];
	endproperty
	a_restart_off: assert property (p_restart_off) else $error("restart with autoneg off"); // RL7
	property p_jab_latch;
		@(posedge i_clk_sys) disable iff (!i_rst_n) line_q.jabber_seen |=> jab_lat_q;
	endproperty
	a_jab_latch: assert property (p_jab_latch) else $error("jabber not latched"); // RL17
	property p_link_low;
		@(posedge i_clk_sys) disable iff (!i_rst_n) (!line_q.link_up) |=> !link_lat_q;
	endproperty
	a_link_low: assert property (p_link_low) else $error("link drop not latched"); // RL16
	property p_rf_hold;
		@(posedge i_clk_sys) disable iff (!i_rst_n) (rf_lat_q && !stat_read) |=> rf_lat_q;
	endproperty
	a_rf_hold: assert property (p_rf_hold) else $error("remote fault lost before read"); // RL15
	property p_fixed_abil;
		@(posedge i_clk_sys) disable iff (!i_rst_n) (stat_word & 16'hffc9) == 16'h7949;
	endproperty
	a_fixed_abil: assert property (p_fixed_abil) else $error("ability bits wrong"); // RL12
	// Soft reset, power down and detach keep the MAC side quiet; COL stays low without collision test
	property p_rst_detach;
		@(posedge i_clk_sys) disable iff (!i_rst_n) ctrl_q[`PBM_CTRL_SOFT_RST] |-> o_mac_oe_n;
	endproperty
	a_rst_detach: assert property (p_rst_detach) else $error("MAC driven during soft reset"); // RL1
	property p_pd_quiet;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			ctrl_q[`PBM_CTRL_PWR_DOWN] |=> (!o_rx_dv && !o_line_tx_en && !o_col);
	endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("MAC active in power down"); // RL5
	property p_detach_quiet;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			ctrl_q[`PBM_CTRL_DETACH] |=> (!o_rx_dv && !o_line_tx_en && !o_col);
	endproperty
	a_detach_quiet: assert property (p_detach_quiet) else $error("MAC inputs used when detached"); // RL6
	property p_col_off;
		@(posedge i_clk_sys) disable iff (!i_rst_n) !ctrl_q[`PBM_CTRL_COL_TEST] |=> !o_col;
	endproperty
	a_col_off: assert property (p_col_off) else $error("collision without collision test"); // RL2
	// Register writes
	property p_ro_regs;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(acc.wr && acc.reg_addr != `PBM_ADDR_CTRL && !ctrl_q[`PBM_CTRL_SOFT_RST] && !i_an_started)
			|=> $stable(ctrl_q);
	endproperty
	a_ro_regs: assert property (p_ro_regs) else $error("write to read-only register changed state"); // RL11 RL20
	property p_ctrl_write;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(acc.wr && acc.reg_addr == `PBM_ADDR_CTRL && !ctrl_q[`PBM_CTRL_SOFT_RST])
			|=> (ctrl_q[14:10] == $past(acc.wdata[14:10]));
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost"); // RL10
	property p_restart_clear;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(i_an_started && !ctrl_q[`PBM_CTRL_SOFT_RST] && !(acc.wr && acc.reg_addr == `PBM_ADDR_CTRL))
			|=> !ctrl_q[`PBM_CTRL_AN_RESTART];
	endproperty
	a_restart_clear: assert property (p_restart_clear) else $error("restart bit not self-cleared"); // RL21
	// Mode resolution
	property p_speed_100;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(!ctrl_q[`PBM_CTRL_AN_EN] && !ctrl_q[`PBM_CTRL_SPD_HIGH] && ctrl_q[`PBM_CTRL_SPD_LOW])
			|-> (o_mode.speed == pbm_pkg::PBM_SPD_100);
	endproperty
	a_speed_100: assert property (p_speed_100) else $error("forced speed not applied"); // RL3
	property p_an_override;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			ctrl_q[`PBM_CTRL_AN_EN] |-> (o_mode.full_duplex && o_mode.speed == pbm_pkg::PBM_SPD_1000);
	endproperty
	a_an_override: assert property (p_an_override) else $error("forced bits used with autoneg on"); // RL4
	property p_duplex_forced;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
			(!ctrl_q[`PBM_CTRL_AN_EN] && !ctrl_q[`PBM_CTRL_LOOPBACK] && !ctrl_q[`PBM_CTRL_SPD_HIGH])
			|-> (o_mode.full_duplex == ctrl_q[`PBM_CTRL_DUPLEX]);
	endproperty
	a_duplex_forced: assert property (p_duplex_forced) else $error("forced duplex not applied"); // RL8
	// Latched status flags
	property p_rf_latch;
		@(posedge i_clk_sys) disable iff (!i_rst_n) line_q.remote_fault |=> rf_lat_q;
	endproperty
	a_rf_latch: assert property (p_rf_latch) else $error("remote fault not latched"); // RL15
	property p_link_follow;
		@(posedge i_clk_sys) disable iff (!i_rst_n) (stat_read && line_q.link_up) |=> link_lat_q;
	endproperty
	a_link_follow: assert property (p_link_follow) else $error("link not refreshed by read"); // RL23
	property p_jab_clear;
		@(posedge i_clk_sys) disable iff (!i_rst_n) (stat_read && !line_q.jabber_seen) |=> !jab_lat_q;
	endproperty
	a_jab_clear: assert property (p_jab_clear) else $error("jabber not cleared by read"); // RL23
endmodule
`default_nettype wire

// ---- hw/pbm_mdio_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbm_regs_map.svh"
// Clause 22 serial slave; samples the management clock with the system clock
module pbm_mdio_slave (
	// Clock and reset
	input  wire logic             i_clk_sys,
	input  wire logic             i_rst_n,
	// Pins
	input  wire logic             i_mdc,
	input  wire logic             i_mdio,
	input  wire logic [4:0]       i_phy_addr,
	output logic                  o_mdio,
	output logic                  o_mdio_oe_n,
	// Register side
	output pbm_pkg::pbm_acc_t     o_acc,
	output logic                  o_rd_start,
	input  wire logic [15:0]      i_rdata
);
	typedef enum logic [2:0] {PBM_IDLE, PBM_HDR, PBM_TA, PBM_WDATA, PBM_RDATA} pbm_mst_t;
	logic [1:0]  mdc_sync_q;
	logic [1:0]  dio_sync_q;
	logic        mdc_last_q;
	pbm_mst_t    st_q;
	logic [5:0]  cnt_q;
	logic [15:0] sh_q;
	logic        mine_q;
	logic        rd_q;
	logic [4:0]  ra_q;
	logic [15:0] rsh_q;
	logic        rise;
	logic        fall;
	// Two-stage synchronisers for clock and data pins
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mdc_sync_q <= 2'h0;
			dio_sync_q <= 2'h3;
			mdc_last_q <= 1'b0;
		end else begin
			mdc_sync_q <= {mdc_sync_q[0], i_mdc};
			dio_sync_q <= {dio_sync_q[0], i_mdio};
			mdc_last_q <= mdc_sync_q[1];
		end
	end
	assign rise = mdc_sync_q[1] & ~mdc_last_q;
	assign fall = ~mdc_sync_q[1] & mdc_last_q;
	// Frame state machine; preamble is optional, a 0 then 1 starts a frame
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_q   <= PBM_IDLE;
			cnt_q  <= 6'h0;
			sh_q   <= 16'hffff; // Idle line reads high, so no false start bit
			mine_q <= 1'b0;
			rd_q   <= 1'b0;
			ra_q   <= 5'h0;
			o_acc  <= '0;
		end else begin
			o_acc.wr <= 1'b0;
			o_acc.rd <= 1'b0;
			if (rise) begin
				sh_q <= {sh_q[14:0], dio_sync_q[1]};
				unique case (st_q)
					PBM_IDLE: begin
						if ({sh_q[0], dio_sync_q[1]} == `PBM_ST) begin
							st_q  <= PBM_HDR;
							cnt_q <= 6'h0;
						end
					end
					PBM_HDR: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'hb) begin
							mine_q <= (sh_q[8:4] == i_phy_addr);
							rd_q   <= (sh_q[10:9] == `PBM_OP_RD);
							ra_q   <= {sh_q[3:0], dio_sync_q[1]};
							st_q   <= PBM_TA;
							cnt_q  <= 6'h0;
						end
					end
					PBM_TA: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'h1) begin
							st_q  <= rd_q ? PBM_RDATA : PBM_WDATA;
							cnt_q <= 6'h0;
						end
					end
					PBM_WDATA: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'hf) begin
							o_acc.wr       <= mine_q;
							o_acc.reg_addr <= ra_q;
							o_acc.wdata    <= {sh_q[14:0], dio_sync_q[1]};
							st_q           <= PBM_IDLE;
							sh_q           <= 16'hffff;
						end
					end
					PBM_RDATA: begin
						cnt_q <= cnt_q + 6'h1;
						if (cnt_q == 6'hf) begin
							st_q <= PBM_IDLE;
							sh_q <= 16'hffff;
						end
					end
					default: st_q <= PBM_IDLE;
				endcase
			end
			if (rise && st_q == PBM_TA && cnt_q == 6'h0 && rd_q && mine_q) begin
				o_acc.rd       <= 1'b1;
				o_acc.reg_addr <= ra_q;
			end
		end
	end
	assign o_rd_start = o_acc.rd;
	// Read data shifted out on falling clock edges
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rsh_q       <= 16'h0;
			o_mdio      <= 1'b1;
			o_mdio_oe_n <= 1'b1;
		end else begin
			if (o_acc.rd) begin
				rsh_q <= i_rdata;
			end
			if (fall) begin
				if (st_q == PBM_TA && cnt_q == 6'h1 && mine_q && rd_q) begin
					o_mdio      <= 1'b0;
					o_mdio_oe_n <= 1'b0;
				end else if (st_q == PBM_RDATA && mine_q) begin
					o_mdio      <= rsh_q[15];
					rsh_q       <= {rsh_q[14:0], 1'b0};
					o_mdio_oe_n <= 1'b0;
				end else begin
					o_mdio_oe_n <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/pbm_pkg.sv ----
package pbm_pkg;
	// Operating mode resolved from control bits
	typedef enum logic [1:0] {
		PBM_SPD_10,
		PBM_SPD_100,
		PBM_SPD_1000,
		PBM_SPD_RSVD
	} pbm_speed_t;
	typedef struct packed {
		logic       loopback;
		logic       power_down;
		logic       mac_detach;
		logic       col_test;
		logic       autoneg_enable;
		logic       full_duplex;
		pbm_speed_t speed;
	} pbm_mode_t;
	// Line-side status inputs
	typedef struct packed {
		logic link_up;
		logic remote_fault;
		logic jabber_seen;
		logic autoneg_done;
	} pbm_line_t;
	// One decoded management access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [4:0]  reg_addr;
		logic [15:0] wdata;
	} pbm_acc_t;
endpackage

// ---- hw/pbm_regs_map.svh ----
`ifndef PBM_REGS_MAP_SVH
`define PBM_REGS_MAP_SVH
// Register addresses (Clause 22 register numbers)
`define PBM_ADDR_CTRL      5'h00
`define PBM_ADDR_STAT      5'h01
`define PBM_ADDR_ID_HIGH   5'h02
// Reset values
`define PBM_CTRL_RESET     16'h1140
`define PBM_STAT_RESET     16'h7949
// Identifier value, arbitrary
`define PBM_ID_HIGH_VALUE  16'h0a5c
// Control bit positions
`define PBM_CTRL_SOFT_RST  15
`define PBM_CTRL_LOOPBACK  14
`define PBM_CTRL_SPD_LOW   13
`define PBM_CTRL_AN_EN     12
`define PBM_CTRL_PWR_DOWN  11
`define PBM_CTRL_DETACH    10
`define PBM_CTRL_AN_RESTART 9
`define PBM_CTRL_DUPLEX    8
`define PBM_CTRL_COL_TEST  7
`define PBM_CTRL_SPD_HIGH  6
// Writable control bits; bits 5:0 are reserved and read as zero
`define PBM_CTRL_WMASK     16'hffc0
// Status bit positions for dynamic flags
`define PBM_STAT_AN_DONE   5
`define PBM_STAT_RFAULT    4
`define PBM_STAT_LINK      2
`define PBM_STAT_JABBER    1
// Fixed part of the status word (dynamic bits cleared)
`define PBM_STAT_FIXED     (16'h7949 & 16'hffc9)
// Soft reset final count; the reset lasts one cycle more than this
`define PBM_SOFT_RST_CYC   4'h8
// Management frame fields
`define PBM_ST             2'b01
`define PBM_OP_WR          2'b01
`define PBM_OP_RD          2'b10
`endif
